/* File: act_counter.sv */
// How it works
// - counter is 16 bits, held as separately addressed low and high bytes
// - reading low byte latches high byte; next high read returns that copy
// - reads never disturb counting
// - 3-bit timebase select: 000 clock/12, 001 clock/4
// - 010 timer0 overflow, 011 external falling edges, 100 clock, 11x none
// - 101 counts external oscillator/8 after synchronising it
// - wrap from all ones to zero sets the overflow flag
// - interrupt requested from the flag only while its enable is one
// - flag is not cleared by service; software writes it to zero
// - idle_suspend clear: counting continues during cpu idle
module act_counter (
  // clock and reset
  input wire logic I_CLK_SYS,
  input wire logic I_RST,
  // axi4-lite write address
  input wire logic [act_pkg::ADDR_W-1:0] I_AXI_AWADDR,
  input wire logic I_AXI_AWVALID,
  output logic O_AXI_AWREADY,
  // axi4-lite write data
  input wire logic [act_pkg::DATA_W-1:0] I_AXI_WDATA,
  input wire logic [3:0] I_AXI_WSTRB,
  input wire logic I_AXI_WVALID,
  output logic O_AXI_WREADY,
  // axi4-lite write response
  output logic [1:0] O_AXI_BRESP,
  output logic O_AXI_BVALID,
  input wire logic I_AXI_BREADY,
  // axi4-lite read address
  input wire logic [act_pkg::ADDR_W-1:0] I_AXI_ARADDR,
  input wire logic I_AXI_ARVALID,
  output logic O_AXI_ARREADY,
  // axi4-lite read data
  output logic [act_pkg::DATA_W-1:0] O_AXI_RDATA,
  output logic [1:0] O_AXI_RRESP,
  output logic O_AXI_RVALID,
  input wire logic I_AXI_RREADY,
  // count sources
  input wire logic I_EXT_COUNT,
  input wire logic I_EXT_OSC_DIV8,
  input wire logic I_T0_OVF,
  // cpu state
  input wire logic I_CPU_IDLE,
  // interrupt
  output logic O_IRQ
);

  function automatic logic known_addr(input logic [act_pkg::ADDR_W-1:0] a);
    known_addr = (a == act_pkg::OFS_COUNT_LOW) ||
      (a == act_pkg::OFS_COUNT_HIGH) || (a == act_pkg::OFS_MODE) ||
      (a == act_pkg::OFS_IRQ_STATUS) || (a == act_pkg::OFS_IRQ_CLEAR) ||
      (a == act_pkg::OFS_IRQ_ENABLE);
  endfunction : known_addr

  // write buffer and handshake state
  logic [act_pkg::ADDR_W-1:0] awaddr_reg;
  logic aw_full_reg;
  logic [act_pkg::BYTE_W-1:0] wbyte_reg;
  logic wlane_reg;
  logic w_full_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic awready_reg;
  logic wready_reg;
  logic arready_reg;
  logic rvalid_reg;
  act_pkg::act_rsp_t rsp_reg;
  act_pkg::act_rsp_t rsp_next;

  // block state
  logic [act_pkg::CNT_W-1:0] count_reg;
  logic [act_pkg::CNT_W-1:0] count_next;
  logic [act_pkg::BYTE_W-1:0] snapshot_reg;
  act_pkg::act_mode_t mode_reg;
  logic flag_reg;
  logic irq_en_reg;
  logic irq_reg;
  logic tick;

  // handshakes
  wire aw_hs = I_AXI_AWVALID & awready_reg;
  wire w_hs = I_AXI_WVALID & wready_reg;
  wire ar_hs = I_AXI_ARVALID & arready_reg;
  wire do_wr = aw_full_reg & w_full_reg & ~bvalid_reg;
  wire aw_full_next = (aw_full_reg | aw_hs) & ~do_wr;
  wire w_full_next = (w_full_reg | w_hs) & ~do_wr;
  wire bvalid_next = (bvalid_reg & ~I_AXI_BREADY) | do_wr;
  wire rvalid_next = (rvalid_reg & ~I_AXI_RREADY) | ar_hs;

  // write decode; only the low byte lane carries data
  wire wr_en = do_wr & wlane_reg;
  wire wr_low = wr_en & (awaddr_reg == act_pkg::OFS_COUNT_LOW);
  wire wr_high = wr_en & (awaddr_reg == act_pkg::OFS_COUNT_HIGH);
  wire wr_mode = wr_en & (awaddr_reg == act_pkg::OFS_MODE);
  wire wr_clear = wr_en & (awaddr_reg == act_pkg::OFS_IRQ_CLEAR);
  wire wr_irq_en = wr_en & (awaddr_reg == act_pkg::OFS_IRQ_ENABLE);

  // read decode
  wire rd_low = ar_hs & (I_AXI_ARADDR == act_pkg::OFS_COUNT_LOW);

  // counting
  wire run = ~(mode_reg.idle_suspend & I_CPU_IDLE);
  wire step = tick & run;
  wire wrap = step & (count_reg == '1) & ~wr_low & ~wr_high;
  // a wrap in the clearing cycle keeps the flag set
  wire flag_clr = (wr_mode & ~wbyte_reg[act_pkg::MODE_FLAG_BIT]) |
    (wr_clear & wbyte_reg[act_pkg::IRQ_OVF_BIT]);
  wire flag_next = wrap | (flag_reg & ~flag_clr);
  wire irq_en_next = wr_irq_en ? wbyte_reg[act_pkg::IRQ_OVF_BIT] : irq_en_reg;
  wire irq_next = flag_next & irq_en_next;

  // register read values
  wire [7:0] mode_rd = {mode_reg.idle_suspend, 3'h0,
    mode_reg.timebase_select, flag_reg};
  wire [7:0] rd_byte =
    (I_AXI_ARADDR == act_pkg::OFS_COUNT_LOW) ? count_reg[7:0] :
    (I_AXI_ARADDR == act_pkg::OFS_COUNT_HIGH) ? snapshot_reg :
    (I_AXI_ARADDR == act_pkg::OFS_MODE) ? mode_rd :
    (I_AXI_ARADDR == act_pkg::OFS_IRQ_STATUS) ? {7'h00, flag_reg} :
    (I_AXI_ARADDR == act_pkg::OFS_IRQ_ENABLE) ? {7'h00, irq_en_reg} :
    8'h00;

  act_timebase u_timebase (
    .i_clk(I_CLK_SYS),
    .i_rst(I_RST),
    .i_sel(mode_reg.timebase_select),
    .i_ext_count(I_EXT_COUNT),
    .i_ext_osc_div8(I_EXT_OSC_DIV8),
    .i_t0_ovf(I_T0_OVF),
    .o_tick(tick)
  );

  always_comb
  begin
    count_next = step ? count_reg + 16'h0001 : count_reg;
    if (wr_low)
    begin
      count_next[7:0] = wbyte_reg;
    end
    if (wr_high)
    begin
      count_next[15:8] = wbyte_reg;
    end
    rsp_next = rsp_reg;
    if (ar_hs)
    begin
      rsp_next.data = {24'h000000, rd_byte};
      rsp_next.resp = known_addr(I_AXI_ARADDR) ? act_pkg::RESP_OKAY
        : act_pkg::RESP_SLVERR;
    end
  end

  // bus handshake state
  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_RST)
    begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wbyte_reg <= 8'h00;
      wlane_reg <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= act_pkg::RESP_OKAY;
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rsp_reg <= '0;
    end
    else
    begin
      aw_full_reg <= aw_full_next;
      w_full_reg <= w_full_next;
      if (aw_hs)
      begin
        awaddr_reg <= I_AXI_AWADDR;
      end
      if (w_hs)
      begin
        wbyte_reg <= I_AXI_WDATA[7:0];
        wlane_reg <= I_AXI_WSTRB[0];
      end
      awready_reg <= ~aw_full_next;
      wready_reg <= ~w_full_next;
      bvalid_reg <= bvalid_next;
      if (do_wr)
      begin
        bresp_reg <= known_addr(awaddr_reg) ? act_pkg::RESP_OKAY
          : act_pkg::RESP_SLVERR;
      end
      arready_reg <= ~rvalid_next;
      rvalid_reg <= rvalid_next;
      rsp_reg <= rsp_next;
    end
  end

  // counter, snapshot, mode and interrupt state
  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_RST)
    begin
      count_reg <= act_pkg::RST_COUNT;
      snapshot_reg <= 8'h00;
      mode_reg.idle_suspend <= act_pkg::RST_IDLE;
      mode_reg.timebase_select <= act_pkg::RST_SEL;
      flag_reg <= 1'b0;
      irq_en_reg <= act_pkg::RST_IRQ_EN;
      irq_reg <= 1'b0;
    end
    else
    begin
      count_reg <= count_next;
      if (rd_low)
      begin
        snapshot_reg <= count_reg[15:8];
      end
      if (wr_mode)
      begin
        mode_reg.idle_suspend <= wbyte_reg[act_pkg::MODE_IDLE_BIT];
        mode_reg.timebase_select <=
          wbyte_reg[act_pkg::MODE_SEL_LSB +: act_pkg::SEL_W];
      end
      flag_reg <= flag_next;
      irq_en_reg <= irq_en_next;
      irq_reg <= irq_next;
    end
  end

  assign O_AXI_AWREADY = awready_reg;
  assign O_AXI_WREADY = wready_reg;
  assign O_AXI_BVALID = bvalid_reg;
  assign O_AXI_BRESP = bresp_reg;
  assign O_AXI_ARREADY = arready_reg;
  assign O_AXI_RVALID = rvalid_reg;
  assign O_AXI_RDATA = rsp_reg.data;
  assign O_AXI_RRESP = rsp_reg.resp;
  assign O_IRQ = irq_reg;

endmodule : act_counter

/* File: act_counter_properties.sv */
module act_counter_properties (
  // clock and reset
  input wire logic I_CLK_SYS,
  input wire logic I_RST,
  // bus
  input wire logic I_AXI_AWVALID,
  input wire logic O_AXI_AWREADY,
  input wire logic [1:0] O_AXI_BRESP,
  input wire logic O_AXI_BVALID,
  input wire logic I_AXI_BREADY,
  input wire logic I_AXI_ARVALID,
  input wire logic O_AXI_ARREADY,
  input wire logic [act_pkg::DATA_W-1:0] O_AXI_RDATA,
  input wire logic O_AXI_RVALID,
  input wire logic I_AXI_RREADY,
  // interrupt
  input wire logic O_IRQ
);
  default clocking cb @(posedge I_CLK_SYS);
  endclocking
  default disable iff (I_RST);
  sequence ar_take;
    I_AXI_ARVALID && O_AXI_ARREADY;
  endsequence
  sequence aw_take;
    I_AXI_AWVALID && O_AXI_AWREADY;
  endsequence
  read_answer_a: assert property (ar_take |=> O_AXI_RVALID && !O_AXI_ARREADY)
    else $error("read not answered in one cycle");
  write_busy_a: assert property (aw_take |=> !O_AXI_AWREADY)
    else $error("write address taken twice");
  write_resp_a: assert property (aw_take |-> ##[1:8] O_AXI_BVALID)
    else $error("write response missing");
  rdata_hold_a: assert property (O_AXI_RVALID && !I_AXI_RREADY |=>
    O_AXI_RVALID && $stable(O_AXI_RDATA))
    else $error("read data dropped");
  bresp_hold_a: assert property (O_AXI_BVALID && !I_AXI_BREADY |=>
    O_AXI_BVALID && $stable(O_AXI_BRESP))
    else $error("write response dropped");
  byte_wide_a: assert property (O_AXI_RVALID |-> O_AXI_RDATA[31:8] == 24'h0)
    else $error("read data wider than a byte");
  irq_fall_a: assert property ($fell(O_IRQ) |->
    O_AXI_BVALID || $past(O_AXI_BVALID))
    else $error("interrupt cleared without a write");
  irq_reset_a: assert property ($past(I_RST) |-> !O_IRQ)
    else $error("interrupt high out of reset");
endmodule : act_counter_properties

bind act_counter act_counter_properties i_props (
  .I_CLK_SYS(I_CLK_SYS), .I_RST(I_RST), .I_AXI_AWVALID(I_AXI_AWVALID),
  .O_AXI_AWREADY(O_AXI_AWREADY), .O_AXI_BRESP(O_AXI_BRESP),
  .O_AXI_BVALID(O_AXI_BVALID), .I_AXI_BREADY(I_AXI_BREADY),
  .I_AXI_ARVALID(I_AXI_ARVALID), .O_AXI_ARREADY(O_AXI_ARREADY),
  .O_AXI_RDATA(O_AXI_RDATA), .O_AXI_RVALID(O_AXI_RVALID),
  .I_AXI_RREADY(I_AXI_RREADY), .O_IRQ(O_IRQ));

/* File: act_pkg.sv */
package act_pkg;

  // widths
  localparam int unsigned CNT_W = 16;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned SEL_W = 3;

  // register byte addresses
  localparam logic [7:0] OFS_COUNT_LOW = 8'h00;
  localparam logic [7:0] OFS_COUNT_HIGH = 8'h04;
  localparam logic [7:0] OFS_MODE = 8'h08;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h0C;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h10;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h14;

  // counter_mode_reg field positions
  localparam int unsigned MODE_FLAG_BIT = 0;
  localparam int unsigned MODE_SEL_LSB = 1;
  localparam int unsigned MODE_IDLE_BIT = 7;
  // status, clear and enable share one layout
  localparam int unsigned IRQ_OVF_BIT = 0;

  // reset values
  localparam logic [CNT_W-1:0] RST_COUNT = 16'h0000;
  localparam logic [SEL_W-1:0] RST_SEL = 3'h0;
  localparam logic RST_IDLE = 1'b0;
  localparam logic RST_IRQ_EN = 1'b0;

  // timebase codes
  localparam logic [SEL_W-1:0] TB_DIV12 = 3'h0;
  localparam logic [SEL_W-1:0] TB_DIV4 = 3'h1;
  localparam logic [SEL_W-1:0] TB_T0_OVF = 3'h2;
  localparam logic [SEL_W-1:0] TB_EXT_FALL = 3'h3;
  localparam logic [SEL_W-1:0] TB_SYSCLK = 3'h4;
  localparam logic [SEL_W-1:0] TB_EXT_OSC8 = 3'h5;

  // prescaler divide ratios
  localparam int unsigned DIV_SLOW = 12;
  localparam int unsigned DIV_FAST = 4;

  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic idle_suspend;
    logic [SEL_W-1:0] timebase_select;
  } act_mode_t;

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic [1:0] resp;
  } act_rsp_t;

endpackage : act_pkg

/* File: act_timebase.sv */
module act_timebase (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // selection and sources
  input wire logic [act_pkg::SEL_W-1:0] i_sel,
  input wire logic i_ext_count,
  input wire logic i_ext_osc_div8,
  input wire logic i_t0_ovf,
  // one-cycle increment enable
  output logic o_tick
);

  logic eci_meta_reg;
  logic eci_sync_reg;
  logic eci_prev_reg;
  logic osc_meta_reg;
  logic osc_sync_reg;
  logic osc_prev_reg;
  logic [3:0] div_slow_reg;
  logic [1:0] div_fast_reg;
  logic tick_next;

  wire slow_end = (div_slow_reg == 4'(act_pkg::DIV_SLOW - 1));
  wire fast_end = (div_fast_reg == 2'(act_pkg::DIV_FAST - 1));
  // falling edge only; pin must stay under a quarter of the clock rate
  wire eci_fall = eci_prev_reg & ~eci_sync_reg;
  // divided oscillator counted on its rising edge after sync
  wire osc_rise = osc_sync_reg & ~osc_prev_reg;

  always_comb
  begin
    unique case (i_sel)
      act_pkg::TB_DIV12: tick_next = slow_end;
      act_pkg::TB_DIV4: tick_next = fast_end;
      act_pkg::TB_T0_OVF: tick_next = i_t0_ovf;
      act_pkg::TB_EXT_FALL: tick_next = eci_fall;
      act_pkg::TB_SYSCLK: tick_next = 1'b1;
      act_pkg::TB_EXT_OSC8: tick_next = osc_rise;
      default: tick_next = 1'b0;
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      eci_meta_reg <= 1'b1;
      eci_sync_reg <= 1'b1;
      eci_prev_reg <= 1'b1;
      osc_meta_reg <= 1'b0;
      osc_sync_reg <= 1'b0;
      osc_prev_reg <= 1'b0;
      div_slow_reg <= 4'h0;
      div_fast_reg <= 2'h0;
      o_tick <= 1'b0;
    end
    else
    begin
      eci_meta_reg <= i_ext_count;
      eci_sync_reg <= eci_meta_reg;
      eci_prev_reg <= eci_sync_reg;
      osc_meta_reg <= i_ext_osc_div8;
      osc_sync_reg <= osc_meta_reg;
      osc_prev_reg <= osc_sync_reg;
      div_slow_reg <= slow_end ? 4'h0 : div_slow_reg + 4'h1;
      div_fast_reg <= fast_end ? 2'h0 : div_fast_reg + 2'h1;
      o_tick <= tick_next;
    end
  end

endmodule : act_timebase

/* File: tb.sv */
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [7:0] wa, wd, ra, er;
    logic [1:0] eb, rr;
  } act_row_t;
  act_row_t rows [6] = '{
    '{8'h14, 8'h01, 8'h14, 8'h01, 2'h0, 2'h0},
    '{8'h14, 8'hFE, 8'h14, 8'h00, 2'h0, 2'h0},
    '{8'h08, 8'hF1, 8'h08, 8'h80, 2'h0, 2'h0},
    '{8'h08, 8'h01, 8'h08, 8'h00, 2'h0, 2'h0},
    '{8'h10, 8'h01, 8'h10, 8'h00, 2'h0, 2'h0},
    '{8'h18, 8'h55, 8'hFC, 8'h00, 2'h2, 2'h2}};
  // ticks in a 48-cycle open window, per timebase code
  int exp_ticks [8] = '{4, 12, 5, 4, 48, 4, 0, 0};
  logic clk = 1'b0, rst = 1'b1, idle = 1'b1, ext = 1'b1;
  logic osc = 1'b0, t0 = 1'b0, irq;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rv;
  logic [1:0] bresp, rresp, rp, bp;
  int fail_count = 0, samples_checked = 0;
  always #50 clk = ~clk;
  act_counter i_dut (.I_CLK_SYS(clk), .I_RST(rst),
    .I_AXI_AWADDR(awaddr), .I_AXI_AWVALID(awvalid),
    .O_AXI_AWREADY(awready), .I_AXI_WDATA(wdata), .I_AXI_WSTRB(4'hF),
    .I_AXI_WVALID(wvalid), .O_AXI_WREADY(wready), .O_AXI_BRESP(bresp),
    .O_AXI_BVALID(bvalid), .I_AXI_BREADY(bready), .I_AXI_ARADDR(araddr),
    .I_AXI_ARVALID(arvalid), .O_AXI_ARREADY(arready),
    .O_AXI_RDATA(rdata), .O_AXI_RRESP(rresp), .O_AXI_RVALID(rvalid),
    .I_AXI_RREADY(rready), .I_EXT_COUNT(ext), .I_EXT_OSC_DIV8(osc),
    .I_T0_OVF(t0), .I_CPU_IDLE(idle), .O_IRQ(irq));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // handshakes judged at the negedge, where registered readies are settled
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic ad, wd, bd, bv;
    bd = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!bd)
    begin
      @(negedge clk);
      ad = awvalid && awready;
      wd = wvalid && wready;
      bv = bvalid;
      bd = bvalid && bready;
      bp = bresp;
      @(posedge clk);
      if (ad)
        awvalid <= 1'b0;
      if (wd)
        wvalid <= 1'b0;
      bready <= bv && !bd;
    end
  endtask : wr
  task automatic rd(input logic [7:0] a);
    logic ad, got, v;
    got = 1'b0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    while (!got)
    begin
      @(negedge clk);
      ad = arvalid && arready;
      v = rvalid;
      got = rvalid && rready;
      rv = rdata;
      rp = rresp;
      @(posedge clk);
      if (ad)
        arvalid <= 1'b0;
      rready <= v && !got;
    end
  endtask : rd
  task automatic stop_test;
    $display("checks=%0d mismatches=%0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : stop_test
  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    stop_test();
  end
  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[i])
    begin
      wr(rows[i].wa, rows[i].wd);
      chk(bp, rows[i].eb);
      rd(rows[i].ra);
      chk(rv, rows[i].er);
      chk(rp, rows[i].rr);
    end
    $display("test registers done");
    // count frozen by idle while set up, then opened for 48 cycles
    for (int s = 0; s < 8; s++)
    begin
      wr(8'h08, {1'b1, 3'h0, s[2:0], 1'b1});
      wr(8'h00, 8'h00);
      wr(8'h04, 8'h00);
      for (int c = 0; c < 48; c++)
      begin
        @(posedge clk);
        idle <= 1'b0;
        t0 <= (c % 8 == 4) && (c < 40);
        ext <= !((c >= 8) && (c < 40) && c[2]);
        osc <= (c >= 8) && (c < 40) && c[2];
      end
      @(posedge clk);
      idle <= 1'b1;
      rd(8'h00);
      chk(rv, exp_ticks[s]);
    end
    $display("test timebase done");
    // count every clock, frozen while idle until the window opens
    wr(8'h08, 8'h89);
    wr(8'h04, 8'h12);
    @(posedge clk);
    idle <= 1'b0;
    rd(8'h00);
    repeat (300) @(posedge clk);
    rd(8'h04);
    chk(rv, 32'h12);
    rd(8'h00);
    rd(8'h04);
    chk(rv > 32'h12, 1);
    $display("test snapshot done");
    wr(8'h04, 8'hFF);
    wr(8'h00, 8'hC0);
    repeat (80) @(posedge clk);
    rd(8'h0C);
    chk(rv, 1);
    chk(irq, 0);
    wr(8'h14, 8'h01);
    repeat (20) @(negedge clk);
    chk(irq, 1);
    wr(8'h14, 8'h00);
    @(negedge clk);
    chk(irq, 0);
    wr(8'h14, 8'h01);
    wr(8'h10, 8'h01);
    @(negedge clk);
    chk(irq, 0);
    $display("test overflow done");
    wr(8'h08, 8'h09);
    idle <= 1'b1;
    rd(8'h00);
    wdata <= rv;
    rd(8'h00);
    chk(rv != wdata, 1);
    wr(8'h08, 8'h89);
    rd(8'h00);
    wdata <= rv;
    rd(8'h00);
    chk(rv, wdata);
    @(posedge clk);
    rst <= 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd(8'h08);
    chk(rv, 0);
    rd(8'h14);
    chk(rv, 0);
    $display("test reset done");
    stop_test();
  end
endmodule : tb
